// file: logic/sism_top.sv
// Second interrupt channel: event flags, masks, raw status and interrupt line control.
// Notes on behaviour
// - pin flags set on either edge.
// - flags stay until host writes one.
// - timer flags set on expiry rising edge.
// - log not-empty, full, watermark rising-edge flags.
// - DMA raw when all enabled buffers done.
// - DSP start, busy, fault rising-edge flags.
// - one mask per flag, one masks, reset one.
// - control port fault raw bit twelve.
// - boot raw bit; host waits for it.
// - DSP and system clock shortfall raw bits.
// - loop reference lost and lock raw bits.
// - jack present when detect pin low; clamp.
// - signal detect raw bits for inputs, compressors.
// - speaker and four leg short raw bits.
// - enable and disable done raw bits.
// - speaker warning, limit and forced-off raw bits.
// - live pin levels on bits fourteen down.
// - log raw not-empty, full, watermark bits.
// - primary line mask bit eleven, reset zero.
// - polarity bit ten, reset active low.
// - summary is OR of unmasked flags.
// - secondary line mask bit eleven.
// - drive type bit nine, open drain.
`timescale 1ns/100ps
module sism_top
  import sism_pkg::*;
#(
  parameter int DMA_WRITE_BUFFERS = 4,
  parameter int DMA_READ_BUFFERS = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [PIN_COUNT-1:0] i_pin_level,
  input wire logic [1:0] i_timer_expired,
  input wire logic [1:0] i_log_not_empty,
  input wire logic [1:0] i_log_full,
  input wire logic [1:0] i_log_watermark,
  input wire logic [DMA_WRITE_BUFFERS-1:0] i_dma_write_enabled,
  input wire logic [DMA_WRITE_BUFFERS-1:0] i_dma_write_filled,
  input wire logic [DMA_READ_BUFFERS-1:0] i_dma_read_enabled,
  input wire logic [DMA_READ_BUFFERS-1:0] i_dma_read_emptied,
  input wire logic i_dsp_start_one,
  input wire logic i_dsp_start_two,
  input wire logic i_dsp_busy,
  input wire logic i_dsp_bus_fault,
  input wire logic i_control_port_fault,
  input wire logic i_boot_complete,
  input wire logic i_loop_ref_lost,
  input wire logic i_dsp_clock_shortfall,
  input wire logic i_system_clock_shortfall,
  input wire logic i_loop_locked,
  input wire logic i_first_loop_locked,
  input wire logic i_mic_clamp_active,
  input wire logic i_jack_one_detect_n,
  input wire logic i_jack_two_detect_n,
  input wire logic [2:0] i_signal_present,
  input wire logic i_speaker_short,
  input wire logic [3:0] i_leg_short,
  input wire logic [2:0] i_power_up_done,
  input wire logic [2:0] i_power_down_done,
  input wire logic [2:0] i_speaker_thermal,
  input wire logic i_primary_summary,
  output logic o_secondary_summary,
  output logic o_primary_line,
  output logic o_primary_line_oe_n,
  output logic o_secondary_line,
  output logic o_secondary_line_oe_n
);

  // Which event lanes also fire on a falling edge: only the general-purpose pins.
  localparam logic [EV_COUNT-1:0] EV_BOTH_EDGES = 28'h0007fff;

  logic dma_done;
  logic [EV_COUNT-1:0] ev_raw;
  logic [EV_COUNT-1:0] ev_flags;
  logic [EV_COUNT-1:0] ev_mask;
  logic [EV_COUNT-1:0] ev_clear;
  logic [EV_COUNT-1:0] mask_sel;
  logic [EV_COUNT-1:0] mask_data;
  logic [15:0] primary_ctrl;
  logic [15:0] secondary_ctrl;
  logic next_summary;
  logic mask_hit;
  logic [15:0] next_rdata;

  // The transfer-done condition is registered so that the wide AND of buffer states
  // settles before the edge detector samples it; this costs one cycle of latency.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dma_done <= 1'b0;
    end else begin
      dma_done <= (&(~i_dma_write_enabled | i_dma_write_filled)) &
                  (&(~i_dma_read_enabled | i_dma_read_emptied));
    end
  end

  // Gather every edge-triggered source into one packed vector.
  always_comb begin
    ev_raw = EV_FLAG_RESET;
    ev_raw[EV_PIN +: PIN_COUNT] = i_pin_level;
    ev_raw[EV_TIMER +: 2] = i_timer_expired;
    ev_raw[EV_LOG_NE +: 2] = i_log_not_empty;
    ev_raw[EV_LOG_FULL +: 2] = i_log_full;
    ev_raw[EV_LOG_WM +: 2] = i_log_watermark;
    ev_raw[EV_DMA] = dma_done;
    ev_raw[EV_START1] = i_dsp_start_one;
    ev_raw[EV_START2] = i_dsp_start_two;
    ev_raw[EV_BUSY] = i_dsp_busy;
    ev_raw[EV_BUS_FAULT] = i_dsp_bus_fault;
  end

  // A write of ones at a flag offset clears exactly those flags; zeros do nothing.
  assign ev_clear = i_wr ? sism_ev_place(i_addr, i_wdata) : EV_FLAG_RESET;

  // Sticky flags with edge detection against the previous clock sample.
  sism_edge_flags #(
    .WIDTH(EV_COUNT),
    .BOTH_EDGES(EV_BOTH_EDGES)
  ) u_flags (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_raw(ev_raw),
    .i_clear(ev_clear),
    .o_flags(ev_flags)
  );

  // Mask offsets mirror the flag offsets one bank higher; undefined bits are dropped.
  assign mask_hit = (i_addr >= OFF_MASK_FIRST) && (i_addr <= OFF_MASK_LAST);
  assign mask_sel = sism_ev_place(16'(i_addr - OFF_MASK_DELTA), 16'hffff);
  assign mask_data = sism_ev_place(16'(i_addr - OFF_MASK_DELTA), i_wdata);

  // Mask bank: a one suppresses the event from the summary, and all start masked.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ev_mask <= EV_MASK_RESET;
    end else if (i_wr && mask_hit) begin
      ev_mask <= (ev_mask & ~mask_sel) | mask_data;
    end
  end

  // Line control registers keep only their defined bits, so the rest read back as zero.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      primary_ctrl <= PRIMARY_CTRL_RESET;
    end else if (i_wr && (i_addr == OFF_PRIMARY_CTRL)) begin
      primary_ctrl <= 16'h0000;
      primary_ctrl[BIT_LINE_MASK] <= i_wdata[BIT_LINE_MASK];
      primary_ctrl[BIT_LINE_POL] <= i_wdata[BIT_LINE_POL];
      primary_ctrl[BIT_LINE_DRIVE] <= i_wdata[BIT_LINE_DRIVE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      secondary_ctrl <= SECONDARY_CTRL_RESET;
    end else if (i_wr && (i_addr == OFF_SECONDARY_CTRL)) begin
      secondary_ctrl <= 16'h0000;
      secondary_ctrl[BIT_LINE_MASK] <= i_wdata[BIT_LINE_MASK];
    end
  end

  // The summary looks at the flags only; a masked flag still reads back as set.
  assign next_summary = |(ev_flags & ~ev_mask);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_secondary_summary <= 1'b0;
    end else begin
      o_secondary_summary <= next_summary;
    end
  end

  // Both lines share polarity and drive type; each has its own mask.
  sism_line_driver u_primary_line (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_active(i_primary_summary),
    .i_mask(primary_ctrl[BIT_LINE_MASK]),
    .i_active_low(primary_ctrl[BIT_LINE_POL]),
    .i_open_drain(primary_ctrl[BIT_LINE_DRIVE]),
    .o_line(o_primary_line),
    .o_line_oe_n(o_primary_line_oe_n)
  );

  sism_line_driver u_secondary_line (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_active(next_summary),
    .i_mask(secondary_ctrl[BIT_LINE_MASK]),
    .i_active_low(primary_ctrl[BIT_LINE_POL]),
    .i_open_drain(primary_ctrl[BIT_LINE_DRIVE]),
    .o_line(o_secondary_line),
    .o_line_oe_n(o_secondary_line_oe_n)
  );

  // Read decode; unmapped addresses and undefined bits read as zero.
  always_comb begin
    next_rdata = 16'h0000;
    if (i_addr == OFF_PIN_EV) begin
      next_rdata[14:0] = ev_flags[EV_PIN +: 15];
    end else if (i_addr == OFF_TIMER_EV) begin
      next_rdata[1:0] = ev_flags[EV_TIMER +: 2];
    end else if (i_addr == OFF_LOG_NE_EV) begin
      next_rdata[1:0] = ev_flags[EV_LOG_NE +: 2];
    end else if (i_addr == OFF_LOG_FULL_EV) begin
      next_rdata[1:0] = ev_flags[EV_LOG_FULL +: 2];
    end else if (i_addr == OFF_LOG_WM_EV) begin
      next_rdata[1:0] = ev_flags[EV_LOG_WM +: 2];
    end else if (i_addr == OFF_DMA_EV) begin
      next_rdata[0] = ev_flags[EV_DMA];
    end else if (i_addr == OFF_START1_EV) begin
      next_rdata[0] = ev_flags[EV_START1];
    end else if (i_addr == OFF_START2_EV) begin
      next_rdata[0] = ev_flags[EV_START2];
    end else if (i_addr == OFF_BUSY_EV) begin
      next_rdata[0] = ev_flags[EV_BUSY];
    end else if (i_addr == OFF_BUS_FAULT_EV) begin
      next_rdata[0] = ev_flags[EV_BUS_FAULT];
    end else if (mask_hit) begin
      // Pick the mask lanes back out of the packed vector for this offset.
      for (int i = 0; i < EV_COUNT; i++) begin
        if (mask_sel[i]) begin
          next_rdata = next_rdata | mask_lane(i_addr, i);
        end
      end
    end else if (i_addr == OFF_CTRL_BOOT_RAW) begin
      next_rdata[BIT_CTRL_FAULT] = i_control_port_fault;
      next_rdata[BIT_BOOT_DONE] = i_boot_complete;
    end else if (i_addr == OFF_CLOCKING_RAW) begin
      next_rdata[BIT_LOOP_REF_LOST] = i_loop_ref_lost;
      next_rdata[BIT_DSP_CLK_SHORT] = i_dsp_clock_shortfall;
      next_rdata[BIT_SYS_CLK_SHORT] = i_system_clock_shortfall;
      next_rdata[BIT_LOOP_LOCKED] = i_loop_locked;
      next_rdata[BIT_FIRST_LOCKED] = i_first_loop_locked;
    end else if (i_addr == OFF_JACK_RAW) begin
      next_rdata[BIT_CLAMP] = i_mic_clamp_active;
      next_rdata[BIT_JACK_TWO] = ~i_jack_two_detect_n;
      next_rdata[BIT_JACK_ONE] = ~i_jack_one_detect_n;
    end else if (i_addr == OFF_SIG_DET_RAW) begin
      next_rdata[2:0] = i_signal_present;
    end else if (i_addr == OFF_SHORT_RAW) begin
      next_rdata[BIT_SPEAKER_LEG] = i_speaker_short;
      next_rdata[3:0] = i_leg_short;
    end else if (i_addr == OFF_EN_DONE_RAW) begin
      next_rdata[BIT_SPEAKER_LEG] = i_power_up_done[2];
      next_rdata[1:0] = i_power_up_done[1:0];
    end else if (i_addr == OFF_DIS_DONE_RAW) begin
      next_rdata[BIT_SPEAKER_LEG] = i_power_down_done[2];
      next_rdata[1:0] = i_power_down_done[1:0];
    end else if (i_addr == OFF_THERMAL_RAW) begin
      next_rdata[2:0] = i_speaker_thermal;
    end else if (i_addr == OFF_PIN_RAW) begin
      next_rdata[PIN_COUNT-1:0] = i_pin_level;
    end else if (i_addr == OFF_LOG_NE_RAW) begin
      next_rdata[1:0] = i_log_not_empty;
    end else if (i_addr == OFF_LOG_FULL_RAW) begin
      next_rdata[1:0] = i_log_full;
    end else if (i_addr == OFF_LOG_WM_RAW) begin
      next_rdata[1:0] = i_log_watermark;
    end else if (i_addr == OFF_DMA_RAW) begin
      next_rdata[0] = dma_done;
    end else if (i_addr == OFF_BUSY_RAW) begin
      next_rdata[0] = i_dsp_busy;
    end else if (i_addr == OFF_PRIMARY_CTRL) begin
      next_rdata = primary_ctrl;
    end else if (i_addr == OFF_SECONDARY_CTRL) begin
      next_rdata = secondary_ctrl;
    end else if (i_addr == OFF_SUMMARY) begin
      next_rdata[BIT_SUM_SECONDARY] = o_secondary_summary;
      next_rdata[BIT_SUM_PRIMARY] = i_primary_summary;
    end
  end

  // Maps one packed mask lane back to its bit position inside its register word.
  function automatic logic [15:0] mask_lane(input logic [15:0] a, input int lane);
    logic [15:0] w;
    int base;
    w = 16'h0000;
    base = (a == 16'(OFF_PIN_EV + OFF_MASK_DELTA)) ? EV_PIN :
           (a == 16'(OFF_TIMER_EV + OFF_MASK_DELTA)) ? EV_TIMER :
           (a == 16'(OFF_LOG_NE_EV + OFF_MASK_DELTA)) ? EV_LOG_NE :
           (a == 16'(OFF_LOG_FULL_EV + OFF_MASK_DELTA)) ? EV_LOG_FULL :
           (a == 16'(OFF_LOG_WM_EV + OFF_MASK_DELTA)) ? EV_LOG_WM : lane;
    w[4'(lane - base)] = ev_mask[lane];
    return w;
  endfunction

  // Read data stand only in the cycle after the read strobe and are zero otherwise.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

// file: logic/sism_pkg.sv
// Shared offsets, field positions, reset values and decode helpers for the event block.
package sism_pkg;

  // Register offsets on the plain register port.
  localparam logic [15:0] OFF_PIN_EV = 16'h1910;
  localparam logic [15:0] OFF_TIMER_EV = 16'h1914;
  localparam logic [15:0] OFF_LOG_NE_EV = 16'h1915;
  localparam logic [15:0] OFF_LOG_FULL_EV = 16'h1916;
  localparam logic [15:0] OFF_LOG_WM_EV = 16'h1917;
  localparam logic [15:0] OFF_DMA_EV = 16'h1918;
  localparam logic [15:0] OFF_START1_EV = 16'h191a;
  localparam logic [15:0] OFF_START2_EV = 16'h191b;
  localparam logic [15:0] OFF_BUSY_EV = 16'h191d;
  localparam logic [15:0] OFF_BUS_FAULT_EV = 16'h1920;
  localparam logic [15:0] OFF_MASK_DELTA = 16'h0040;
  localparam logic [15:0] OFF_MASK_FIRST = 16'h1940;
  localparam logic [15:0] OFF_MASK_LAST = 16'h1960;
  localparam logic [15:0] OFF_CTRL_BOOT_RAW = 16'h1980;
  localparam logic [15:0] OFF_CLOCKING_RAW = 16'h1981;
  localparam logic [15:0] OFF_JACK_RAW = 16'h1986;
  localparam logic [15:0] OFF_SIG_DET_RAW = 16'h1988;
  localparam logic [15:0] OFF_SHORT_RAW = 16'h198b;
  localparam logic [15:0] OFF_EN_DONE_RAW = 16'h198c;
  localparam logic [15:0] OFF_DIS_DONE_RAW = 16'h198d;
  localparam logic [15:0] OFF_THERMAL_RAW = 16'h198e;
  localparam logic [15:0] OFF_PIN_RAW = 16'h1990;
  localparam logic [15:0] OFF_LOG_NE_RAW = 16'h1995;
  localparam logic [15:0] OFF_LOG_FULL_RAW = 16'h1996;
  localparam logic [15:0] OFF_LOG_WM_RAW = 16'h1997;
  localparam logic [15:0] OFF_DMA_RAW = 16'h1998;
  localparam logic [15:0] OFF_BUSY_RAW = 16'h199d;
  localparam logic [15:0] OFF_PRIMARY_CTRL = 16'h1a80;
  localparam logic [15:0] OFF_SECONDARY_CTRL = 16'h1a82;
  localparam logic [15:0] OFF_SUMMARY = 16'h1aa0;

  // Field positions.
  localparam int PIN_COUNT = 15;
  localparam int BIT_CTRL_FAULT = 12;
  localparam int BIT_BOOT_DONE = 7;
  localparam int BIT_LOOP_REF_LOST = 15;
  localparam int BIT_DSP_CLK_SHORT = 14;
  localparam int BIT_SYS_CLK_SHORT = 12;
  localparam int BIT_LOOP_LOCKED = 11;
  localparam int BIT_FIRST_LOCKED = 8;
  localparam int BIT_CLAMP = 4;
  localparam int BIT_JACK_TWO = 2;
  localparam int BIT_JACK_ONE = 0;
  localparam int BIT_SPEAKER_LEG = 6;
  localparam int BIT_LINE_MASK = 11;
  localparam int BIT_LINE_POL = 10;
  localparam int BIT_LINE_DRIVE = 9;
  localparam int BIT_SUM_SECONDARY = 1;
  localparam int BIT_SUM_PRIMARY = 0;

  // Positions of each group inside the packed event vector.
  localparam int EV_PIN = 0;
  localparam int EV_TIMER = 15;
  localparam int EV_LOG_NE = 17;
  localparam int EV_LOG_FULL = 19;
  localparam int EV_LOG_WM = 21;
  localparam int EV_DMA = 23;
  localparam int EV_START1 = 24;
  localparam int EV_START2 = 25;
  localparam int EV_BUSY = 26;
  localparam int EV_BUS_FAULT = 27;
  localparam int EV_COUNT = 28;

  // Values after reset.
  localparam logic [EV_COUNT-1:0] EV_FLAG_RESET = 28'h0000000;
  localparam logic [EV_COUNT-1:0] EV_MASK_RESET = 28'hfffffff;
  localparam logic [15:0] PRIMARY_CTRL_RESET = 16'h0400;
  localparam logic [15:0] SECONDARY_CTRL_RESET = 16'h0000;

  // Spreads a data word over the event vector lanes that live at one flag offset.
  function automatic logic [EV_COUNT-1:0] sism_ev_place(input logic [15:0] a,
                                                        input logic [15:0] d);
    logic [EV_COUNT-1:0] v;
    v = EV_FLAG_RESET;
    if (a == OFF_PIN_EV) begin
      v[EV_PIN +: 15] = d[14:0];
    end else if (a == OFF_TIMER_EV) begin
      v[EV_TIMER +: 2] = d[1:0];
    end else if (a == OFF_LOG_NE_EV) begin
      v[EV_LOG_NE +: 2] = d[1:0];
    end else if (a == OFF_LOG_FULL_EV) begin
      v[EV_LOG_FULL +: 2] = d[1:0];
    end else if (a == OFF_LOG_WM_EV) begin
      v[EV_LOG_WM +: 2] = d[1:0];
    end else if (a == OFF_DMA_EV) begin
      v[EV_DMA] = d[0];
    end else if (a == OFF_START1_EV) begin
      v[EV_START1] = d[0];
    end else if (a == OFF_START2_EV) begin
      v[EV_START2] = d[0];
    end else if (a == OFF_BUSY_EV) begin
      v[EV_BUSY] = d[0];
    end else if (a == OFF_BUS_FAULT_EV) begin
      v[EV_BUS_FAULT] = d[0];
    end
    return v;
  endfunction

endpackage

// file: logic/sism_edge_flags.sv
// Edge detectors feeding a bank of sticky event flags cleared by writing one.
`timescale 1ns/100ps
module sism_edge_flags #(
  parameter int WIDTH = 28,
  parameter logic [WIDTH-1:0] BOTH_EDGES = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_raw,
  input wire logic [WIDTH-1:0] i_clear,
  output logic [WIDTH-1:0] o_flags
);

  logic [WIDTH-1:0] raw_prev;
  logic primed;
  logic [WIDTH-1:0] next_edge;

  // Rising edges always count; selected lanes also count falling edges.
  assign next_edge = primed ? ((i_raw & ~raw_prev) | (BOTH_EDGES & ~i_raw & raw_prev)) : '0;

  // The previous sample is taken on every clock; the first cycle after reset only primes it,
  // so a condition already true at reset does not look like a fresh edge.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      raw_prev <= '0;
      primed <= 1'b0;
    end else begin
      raw_prev <= i_raw;
      primed <= 1'b1;
    end
  end

  // A new edge in the cycle of a clear keeps the flag set.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flags <= '0;
    end else begin
      o_flags <= (o_flags & ~i_clear) | next_edge;
    end
  end

endmodule

// file: logic/sism_line_driver.sv
// Drives one interrupt line with mask, polarity and push-pull or open-drain choice.
`timescale 1ns/100ps
module sism_line_driver (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_active,
  input wire logic i_mask,
  input wire logic i_active_low,
  input wire logic i_open_drain,
  output logic o_line,
  output logic o_line_oe_n
);

  logic level;

  // The logical request, forced inactive by the mask, then given its polarity.
  assign level = (i_active & ~i_mask) ^ i_active_low;

  // Open drain only ever pulls low and lets the wire float for a high level.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_line <= 1'b1;
      o_line_oe_n <= 1'b1;
    end else begin
      o_line <= level;
      o_line_oe_n <= i_open_drain & level;
    end
  end

endmodule

// file: testbench/sism_host_line.sv
// Host-side model of the secondary interrupt pin with its board pull-up.
`timescale 1ns/100ps
module sism_host_line (
  input wire logic i_line,
  input wire logic i_oe_n,
  output logic o_wire
);
  // A released pin floats to the pull-up, so open drain reads high whenever its level is high, which is idle only when active low.
  assign o_wire = i_oe_n ? 1'b1 : i_line;
endmodule

// file: testbench/sism_chk.sv
// Port-level assertions for the event block, bound to its top module.
`timescale 1ns/100ps
module sism_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_primary_summary,
  input wire logic o_secondary_summary,
  input wire logic o_primary_line,
  input wire logic o_primary_line_oe_n,
  input wire logic o_secondary_line,
  input wire logic o_secondary_line_oe_n
);
  logic [2:0] ctl;
  logic [2:0] ctl_q;
  logic m2;
  logic m2_q;
  logic touched;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Shadow of the line controls: bit 2 primary mask, bit 1 polarity, bit 0 open drain.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl <= 3'h2;
      m2 <= 1'b0;
    end else if (i_wr && i_addr == 16'h1a80) begin
      ctl <= i_wdata[11:9];
    end else if (i_wr && i_addr == 16'h1a82) begin
      m2 <= i_wdata[11];
    end
  end

  // Lines lag their controls by one register, so compare against the delayed copy.
  always_ff @(posedge i_clk) begin
    ctl_q <= i_rst ? 3'h2 : ctl;
    m2_q <= i_rst ? 1'b0 : m2;
  end

  // Any mask write ends the all-masked state left by reset.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      touched <= 1'b0;
    end else if (i_wr && i_addr >= 16'h1940 && i_addr <= 16'h1960) begin
      touched <= 1'b1;
    end
  end

  property p_rd_idle;
    !i_rd |=> o_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_mask_reset;
    !touched |-> !o_secondary_summary;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("summary while masked");
  property p_sticky;
    o_secondary_summary && !$past(i_wr) |=> o_secondary_summary;
  endproperty
  a_sticky: assert property (p_sticky) else $error("summary dropped without write");
  property p_sec_masked;
    m2_q |-> o_secondary_line == ctl_q[1];
  endproperty
  a_sec_masked: assert property (p_sec_masked) else $error("masked line active");
  property p_pri_masked;
    ctl_q[2] |-> o_primary_line == ctl_q[1];
  endproperty
  a_pri_masked: assert property (p_pri_masked) else $error("masked primary active");
  property p_pri_follow;
    !ctl_q[2] |-> o_primary_line == ($past(i_primary_summary) ^ ctl_q[1]);
  endproperty
  a_pri_follow: assert property (p_pri_follow) else $error("primary polarity");
  property p_sum_line;
    !m2_q |-> o_secondary_line == (o_secondary_summary ^ ctl_q[1]);
  endproperty
  a_sum_line: assert property (p_sum_line) else $error("line disagrees");
  // The drivers still show their released reset state on the first edge after release.
  property p_push_pull;
    !$past(i_rst) && !ctl_q[0] |-> !o_secondary_line_oe_n && !o_primary_line_oe_n;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull released");
  property p_open_drain;
    ctl_q[0] |-> o_secondary_line_oe_n == o_secondary_line;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drives high");

  c_sum: cover property ($rose(o_secondary_summary));
  c_od: cover property (ctl_q[0] && !o_secondary_line_oe_n);
  c_pri: cover property (!ctl_q[2] && o_primary_line != ctl_q[1]);
endmodule

bind sism_top sism_chk sism_chk_inst (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_primary_summary, .o_secondary_summary, .o_primary_line,
  .o_primary_line_oe_n, .o_secondary_line, .o_secondary_line_oe_n);

// file: testbench/tb.sv
// Self-checking bench for the event block: flags, masks, raw status and lines.
`timescale 1ns/100ps
`define CK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [14:0] pin = 15'h0000;
  logic [11:0] src = 12'h000;
  logic [3:0] dwe = 4'h3;
  logic [3:0] dwf = 4'h0;
  logic [3:0] dre = 4'h0;
  logic [3:0] drm = 4'h0;
  logic [26:0] r = 27'h0000000;
  logic psum = 1'b0;
  logic [15:0] rdata;
  logic sum, pl, pl_oe_n, sl, sl_oe_n, sl_wire;
  logic [15:0] a, e;
  int fails = 0;
  int checks = 0;
  logic [15:0] ra [8] = '{16'h1980, 16'h1981, 16'h1986, 16'h1988, 16'h198b, 16'h198c,
    16'h198d, 16'h198e};
  logic [15:0] re [8] = '{16'h1080, 16'hd900, 16'h0010, 16'h0007, 16'h004f, 16'h0043,
    16'h0043, 16'h0007};
  logic [15:0] so [4] = '{16'h191a, 16'h191b, 16'h191d, 16'h1920};
  int pj [3] = '{0, 4, 14};

  // Free-running 25 MHz clock.
  always #20 i_clk = ~i_clk;

  sism_top sism_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin_level(pin), .i_timer_expired(src[1:0]),
    .i_log_not_empty(src[3:2]), .i_log_full(src[5:4]), .i_log_watermark(src[7:6]),
    .i_dma_write_enabled(dwe), .i_dma_write_filled(dwf), .i_dma_read_enabled(dre),
    .i_dma_read_emptied(drm), .i_dsp_start_one(src[8]), .i_dsp_start_two(src[9]),
    .i_dsp_busy(src[10]), .i_dsp_bus_fault(src[11]), .i_control_port_fault(r[0]),
    .i_boot_complete(r[1]), .i_loop_ref_lost(r[2]), .i_dsp_clock_shortfall(r[3]),
    .i_system_clock_shortfall(r[4]), .i_loop_locked(r[5]), .i_first_loop_locked(r[6]),
    .i_mic_clamp_active(r[7]), .i_jack_one_detect_n(r[8]), .i_jack_two_detect_n(r[9]),
    .i_signal_present(r[12:10]), .i_speaker_short(r[13]), .i_leg_short(r[17:14]),
    .i_power_up_done(r[20:18]), .i_power_down_done(r[23:21]), .i_speaker_thermal(r[26:24]),
    .i_primary_summary(psum), .o_secondary_summary(sum), .o_primary_line(pl),
    .o_primary_line_oe_n(pl_oe_n), .o_secondary_line(sl), .o_secondary_line_oe_n(sl_oe_n));

  sism_host_line sism_host_line_inst (.i_line(sl), .i_oe_n(sl_oe_n), .o_wire(sl_wire));

  // One-cycle write strobe; ends on a rising edge.
  task automatic wr_t(input logic [15:0] ad, input logic [15:0] d);
    @(posedge i_clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd_t(input logic [15:0] ad, input logic [15:0] ex);
    @(posedge i_clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    @(negedge i_clk);
    `CK(rdata, ex)
    @(posedge i_clk);
  endtask

  // Lets flag, summary and line registers ripple, then parks mid-cycle.
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence; boot stays low during the first pass, so only reads are made.
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (ra[k]) rd_t(ra[k], (ra[k] == 16'h1986) ? 16'h0005 : 16'h0000);
    rd_t(16'h1234, 16'h0000);
    rd_t(16'h1a80, 16'h0400);
    rd_t(16'h1a82, 16'h0000);
    r <= '1;
    foreach (ra[k]) rd_t(ra[k], re[k]);
    wr_t(16'h1980, 16'hffff);
    rd_t(16'h1980, 16'h1080);
    foreach (pj[k]) begin
      e = 16'h0001 << pj[k];
      pin <= e[14:0];
      rd_t(16'h1990, e);
      rd_t(16'h1910, e);
      wr_t(16'h1910, e);
      pin <= 15'h0000;
      rd_t(16'h1910, e);
      wr_t(16'h1910, e);
      rd_t(16'h1910, 16'h0000);
    end
    for (int i = 0; i < 12; i++) begin
      a = (i < 8) ? 16'h1914 + 16'(i / 2) : so[i - 8];
      e = (i < 8) ? 16'h0001 << (i % 2) : 16'h0001;
      rd_t(a + 16'h0040, (i < 8) ? 16'h0003 : 16'h0001);
      src[i] <= 1'b1;
      rd_t(a, e);
      if ((i > 1 && i < 8) || i == 10) rd_t(a + 16'h0080, e);
      src[i] <= 1'b0;
      wr_t(a, 16'h0000);
      rd_t(a, e);
      wr_t(a, e);
      rd_t(a, 16'h0000);
    end
    dwf <= 4'h3;
    rd_t(16'h1998, 16'h0001);
    rd_t(16'h1918, 16'h0001);
    dre <= 4'h1;
    rd_t(16'h1998, 16'h0000);
    drm <= 4'h1;
    rd_t(16'h1998, 16'h0001);
    src[0] <= 1'b1;
    rd_t(16'h1914, 16'h0001);
    src[0] <= 1'b0;
    @(posedge i_clk);
    src[0] <= 1'b1;
    addr <= 16'h1914;
    wdata <= 16'h0001;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    rd_t(16'h1914, 16'h0001);
    settle(1);
    `CK(sum, 1'b0)
    wr_t(16'h1954, 16'h0000);
    settle(2);
    `CK(sum, 1'b1)
    `CK({sl, sl_oe_n}, 2'b00)
    rd_t(16'h1aa0, 16'h0002);
    wr_t(16'h1a82, 16'h0800);
    settle(2);
    `CK(sl, 1'b1)
    wr_t(16'h1a82, 16'h0000);
    wr_t(16'h1a80, 16'h0000);
    settle(2);
    `CK(sl, 1'b1)
    wr_t(16'h1a80, 16'h0200);
    settle(2);
    `CK({sl_wire, sl_oe_n}, 2'b11)
    wr_t(16'h1a80, 16'h0600);
    psum <= 1'b1;
    settle(2);
    `CK(sl_wire, 1'b0)
    `CK(pl, 1'b0)
    wr_t(16'h1a80, 16'h0e00);
    settle(2);
    `CK(pl, 1'b1)
    wr_t(16'h1a80, 16'hffff);
    rd_t(16'h1a80, 16'h0e00);
    wr_t(16'h1914, 16'h0001);
    settle(2);
    `CK(sum, 1'b0)
    results();
  end

  // Cuts a hang short well beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (4000) @(posedge i_clk);
    fails++;
    results();
  end
endmodule
